// ---- src/dbw_pkg.sv ----
// constants for the device, bus and wake status register bank
// assumes one 250 MHz core clock and a decoded 7-bit register address
`default_nettype none
package dbw_pkg;
   // register addresses
   localparam logic [6:0] ADDR_DEV = 7'h43;
   localparam logic [6:0] ADDR_BUS = 7'h44;
   localparam logic [6:0] ADDR_WAKE = 7'h46;
   // reset values and reserved fill
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] ZERO2 = 2'h0;
   localparam logic [2:0] ZERO3 = 3'h0;
   localparam logic [4:0] ZERO5 = 5'h0;
   localparam logic ZERO1 = 1'h0;
   // prior state codes
   localparam logic [1:0] PRIOR_CLR = 2'h0;
   localparam logic [1:0] PRIOR_FAIL = 2'h1;
   localparam logic [1:0] PRIOR_SLEEP = 2'h2;
   // watchdog failure counts
   localparam logic [1:0] WD_NONE = 2'h0;
   localparam logic [1:0] WD_ONE = 2'h1;
   localparam logic [1:0] WD_TWO = 2'h2;
   localparam logic [1:0] WD_NEVER = 2'h3;
   // transceiver failure codes
   localparam logic [1:0] FAIL_NONE = 2'h0;
   localparam logic [1:0] FAIL_TSD = 2'h1;
   localparam logic [1:0] FAIL_TXD = 2'h2;
   localparam logic [1:0] FAIL_BUS = 2'h3;
   // timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int DOM_TIMEOUT_US = 2000;
   // cycles per microsecond first, so the product stays inside an int
   localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * (1000000 / CLK_PERIOD_PS);
   localparam int TXEN_TIME_NS = 8;
   localparam int TXEN_CYC = (TXEN_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // pin synchroniser lanes
   localparam int PIN_TXD = 0;
   localparam int PIN_BUSDOM = 1;
   localparam int PIN_UV = 2;
   localparam int PIN_TSD = 3;
   localparam int PIN_CFG = 4;
   localparam int PIN_N = 5;
   typedef enum logic [1:0] {
      TX_OFF = 2'b00,
      TX_RECOVER = 2'b01,
      TX_ON = 2'b10
   } dbw_tx_state_t;
endpackage : dbw_pkg
`default_nettype wire

// ---- src/dbw_dom_timer.sv ----
// dominant-level timeout: flags a condition held longer than LIMIT cycles
// assumes cond and abort are already synchronous to clk
`default_nettype none
module dbw_dom_timer #(
   parameter int LIMIT = 500000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cond,
   input wire logic abort,
   output logic expired,
   output logic active
);
   localparam int W = $clog2(LIMIT + 1);
   localparam logic [W-1:0] LIM = W'(LIMIT);
   logic [W-1:0] cnt;
   wire run = cond && !abort;
   wire hit = run && !active && (cnt == LIM);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         active <= 1'b0;
         expired <= 1'b0;
      end else begin
         // held longer than the limit, so fires on the cycle past it
         cnt <= (run && !active) ? cnt + 1'b1 : (run ? cnt : '0);
         active <= run && (active || hit);
         expired <= hit;
      end
   end

   expire_exact_a: assert property (@(posedge clk) disable iff (!rst_n)
      (run && !active && cnt == LIM) |=> expired && active)
      else $error("timeout did not fire at its limit");
   abort_ends_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!run) |=> !active && !expired)
      else $error("timeout survived its end condition");
endmodule : dbw_dom_timer
`default_nettype wire

// ---- src/dbw_status_regs.sv ----
// device, bus and wake status registers with transceiver fault supervision
// assumes same-clock event pulses from the core and raw transceiver pins
//
// How it works
// - prior state field bits 7:6: cleared, restart by failure, sleep
// - watchdog failure count bits 3:2, saturates at one or two, never three
// - failure count alone clears itself: good trigger or a watchdog stop not caused by failure
// - configurations 2/4 freeze the count until a good trigger
// - serial error bit 1 set on invalid command, cleared by host only
// - fail output bit 0 set when the count reaches its limit; the fail output follows it a cycle later
// - reserved bits of all three registers read zero
// - transceiver failure code bits 2:1: none, thermal, transmit, bus
// - transmit input dominant over 2 ms gives transmit timeout
// - bus dominant over 2 ms gives bus timeout
// - supply undervoltage sets bit 0 and disables the transmitter
// - undervoltage comparator works only while mode high bit is one
// - transmit timeout ends on input high, transmitter off or wake-capable
// - bus timeout ends on recessive bus, wake-capable or switched off
// - undervoltage ends once supply is back above threshold
// - after any fault transmit input high for enable time re-enables
// - wake bit 7 set on automatic buck mode transition
// - wake bits 5, 4, 0 latch bus, timer and wake input sources
// - wake sources also latch when leaving fail-safe mode
// - device register zero on soft reset, restart sets 7:6 and keeps 3:0
// - bus register zero on soft reset, restart keeps 2:0
// - wake register zero on soft reset, restart keeps 7,5,4,0
// - fault flags stay set after the cause is gone until cleared
`default_nettype none
module dbw_status_regs #(
   parameter int DOM_LIMIT = dbw_pkg::DOM_TIMEOUT_CYC,
   parameter int TXEN_LIMIT = dbw_pkg::TXEN_CYC
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic SOFT_RST,
   input wire logic RESTART,
   input wire logic SLEEP_ACTIVE,
   input wire logic WATCHDOG_FAILURE_COUNT_EVT,
   input wire logic WD_TRIG_OK,
   input wire logic WD_STOPPED,
   input wire logic WD_STOP_BY_FAIL,
   input wire logic INTERRUPT_CONFIG_PIN,
   input wire logic CFG_FO_FIRST,
   input wire logic SPI_INVALID,
   input wire logic XCVR0_TRANSMIT_INPUT,
   input wire logic XCVR0_BUS_DOMINANT,
   input wire logic XCVR_SUPPLY_LOW,
   input wire logic THERMAL_SHUTDOWN,
   input wire logic XCVR_MODE_HIGH_BIT,
   input wire logic XCVR_WAKE_CAPABLE,
   input wire logic XCVR_TX_SWITCHED_OFF,
   input wire logic XCVR0_BUS_WAKE,
   input wire logic CYCLIC_TIMER_WAKE,
   input wire logic HV_INPUT_WAKE,
   input wire logic BUCK_MODE_AUTO_TRANSITION,
   input wire logic [6:0] REG_ADDR,
   input wire logic REG_RD,
   input wire logic REG_CLR,
   output logic [7:0] REG_RDATA,
   output logic XCVR0_TX_ENABLE,
   output logic FAIL_OUTPUTS
);
   localparam int TW = $clog2(TXEN_LIMIT + 1);
   localparam logic [TW-1:0] TX_LAST = TW'(TXEN_LIMIT - 1);

   // pin synchronisers
   wire [dbw_pkg::PIN_N-1:0] pin_raw = {INTERRUPT_CONFIG_PIN, THERMAL_SHUTDOWN,
      XCVR_SUPPLY_LOW, XCVR0_BUS_DOMINANT, XCVR0_TRANSMIT_INPUT};
   logic [dbw_pkg::PIN_N-1:0] pin_meta;
   logic [dbw_pkg::PIN_N-1:0] pin_s;
   genvar gi;
   generate
      for (gi = 0; gi < dbw_pkg::PIN_N; gi++) begin : g_sync
         // transmit lane idles high: resetting it low would fake a dominant start
         localparam logic IDLE = (gi == dbw_pkg::PIN_TXD);
         always_ff @(posedge CORE_CLK or negedge RST_N) begin
            if (!RST_N) begin
               pin_meta[gi] <= IDLE;
               pin_s[gi] <= IDLE;
            end else begin
               pin_meta[gi] <= pin_raw[gi];
               pin_s[gi] <= pin_meta[gi];
            end
         end
      end
   endgenerate

   wire txd_s = pin_s[dbw_pkg::PIN_TXD];
   wire busdom_s = pin_s[dbw_pkg::PIN_BUSDOM];
   wire uv_s = pin_s[dbw_pkg::PIN_UV];
   wire tsd_s = pin_s[dbw_pkg::PIN_TSD];
   wire cfg_pin_s = pin_s[dbw_pkg::PIN_CFG];

   // register state
   logic [1:0] prior;
   logic [1:0] wd_count;
   logic wd_frozen;
   logic spi_fail;
   logic fo_flag;
   logic [1:0] fail_code;
   logic uv_flag;
   logic buck_flag;
   logic bus_wake;
   logic timer_wake;
   logic hv_wake;
   logic tsd_q;
   dbw_pkg::dbw_tx_state_t tx_state;
   dbw_pkg::dbw_tx_state_t next_tx_state;
   logic [TW-1:0] tx_cnt;

   // register decode
   wire sel_dev = (REG_ADDR == dbw_pkg::ADDR_DEV);
   wire sel_bus = (REG_ADDR == dbw_pkg::ADDR_BUS);
   wire sel_wake = (REG_ADDR == dbw_pkg::ADDR_WAKE);
   wire clr_dev = REG_CLR && sel_dev;
   wire clr_bus = REG_CLR && sel_bus;
   wire clr_wake = REG_CLR && sel_wake;

   // reserved positions are built in as constant zeros
   wire [7:0] rd_dev = {prior, dbw_pkg::ZERO2, wd_count, spi_fail, fo_flag};
   wire [7:0] rd_bus = {dbw_pkg::ZERO5, fail_code, uv_flag};
   wire [7:0] rd_wake = {buck_flag, dbw_pkg::ZERO1, bus_wake, timer_wake,
      dbw_pkg::ZERO3, hv_wake};
   wire [7:0] rd_mux = sel_dev ? rd_dev :
      sel_bus ? rd_bus :
      sel_wake ? rd_wake : dbw_pkg::RST_BYTE;

   // watchdog failure counter
   // config 2/4 is the low level of the interrupt configuration pin
   wire cfg_freeze = !cfg_pin_s;
   wire [1:0] wd_limit = CFG_FO_FIRST ? dbw_pkg::WD_ONE : dbw_pkg::WD_TWO;
   wire wd_at_limit = (wd_count == wd_limit);
   wire wd_inc = WATCHDOG_FAILURE_COUNT_EVT && !wd_frozen && !wd_at_limit;
   wire [1:0] wd_plus = wd_count + 2'h1;
   wire wd_hits = wd_inc && (wd_plus == wd_limit);
   // a stop caused by the watchdog itself keeps the count visible
   wire wd_auto_clr = WD_TRIG_OK ||
      (WD_STOPPED && !WD_STOP_BY_FAIL && !wd_frozen);
   wire [1:0] next_wd_count = wd_inc ? wd_plus :
      (wd_auto_clr ? dbw_pkg::WD_NONE : wd_count);

   // prior state: set wins over a clear in the same cycle
   wire [1:0] restart_code = SLEEP_ACTIVE ? dbw_pkg::PRIOR_SLEEP : dbw_pkg::PRIOR_FAIL;
   wire [1:0] next_prior = RESTART ? restart_code :
      (clr_dev ? dbw_pkg::PRIOR_CLR : prior);

   // transceiver supervision
   wire txd_exp;
   wire txd_active;
   wire bus_exp;
   wire bus_active;
   wire uv_active = uv_s && XCVR_MODE_HIGH_BIT;
   wire tsd_evt = tsd_s && !tsd_q;
   wire tx_fault = txd_active || bus_active || uv_active || tsd_s;
   wire [1:0] next_fail_code = bus_exp ? dbw_pkg::FAIL_BUS :
      txd_exp ? dbw_pkg::FAIL_TXD :
      tsd_evt ? dbw_pkg::FAIL_TSD :
      (clr_bus ? dbw_pkg::FAIL_NONE : fail_code);

   // transmit input low is dominant
   dbw_dom_timer #(
      .LIMIT(DOM_LIMIT)
   ) u_txd_timer (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .cond(!txd_s),
      .abort(XCVR_TX_SWITCHED_OFF || XCVR_WAKE_CAPABLE),
      .expired(txd_exp),
      .active(txd_active)
   );

   dbw_dom_timer #(
      .LIMIT(DOM_LIMIT)
   ) u_bus_timer (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .cond(busdom_s),
      .abort(XCVR_WAKE_CAPABLE || XCVR_TX_SWITCHED_OFF),
      .expired(bus_exp),
      .active(bus_active)
   );

   // transmitter re-enable after the transmit input stays high
   wire tx_done = txd_s && (tx_cnt == TX_LAST);
   always_comb begin
      next_tx_state = tx_state;
      case (tx_state)
         dbw_pkg::TX_ON: begin
            if (tx_fault) begin
               next_tx_state = dbw_pkg::TX_OFF;
            end
         end
         dbw_pkg::TX_OFF: begin
            if (!tx_fault) begin
               next_tx_state = dbw_pkg::TX_RECOVER;
            end
         end
         dbw_pkg::TX_RECOVER: begin
            if (tx_fault) begin
               next_tx_state = dbw_pkg::TX_OFF;
            end else if (tx_done) begin
               next_tx_state = dbw_pkg::TX_ON;
            end
         end
         default: begin
            next_tx_state = dbw_pkg::TX_OFF;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tx_state <= dbw_pkg::TX_OFF;
         tx_cnt <= '0;
         XCVR0_TX_ENABLE <= 1'b0;
         tsd_q <= 1'b0;
      end else begin
         tx_state <= next_tx_state;
         // any low level restarts the high-time count
         tx_cnt <= (tx_state == dbw_pkg::TX_RECOVER && txd_s && !tx_done) ?
            tx_cnt + 1'b1 : '0;
         XCVR0_TX_ENABLE <= (next_tx_state == dbw_pkg::TX_ON);
         tsd_q <= tsd_s;
      end
   end

   // device status register
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         prior <= dbw_pkg::PRIOR_CLR;
         wd_count <= dbw_pkg::WD_NONE;
         wd_frozen <= 1'b0;
         spi_fail <= 1'b0;
         fo_flag <= 1'b0;
      end else if (SOFT_RST) begin
         prior <= dbw_pkg::PRIOR_CLR;
         wd_count <= dbw_pkg::WD_NONE;
         wd_frozen <= 1'b0;
         spi_fail <= 1'b0;
         fo_flag <= 1'b0;
      end else begin
         prior <= next_prior;
         wd_count <= next_wd_count;
         wd_frozen <= WD_TRIG_OK ? 1'b0 : (wd_frozen || (wd_hits && cfg_freeze));
         spi_fail <= SPI_INVALID || (spi_fail && !clr_dev);
         fo_flag <= wd_hits || (fo_flag && !clr_dev);
      end
   end

   // bus status register
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         fail_code <= dbw_pkg::FAIL_NONE;
         uv_flag <= 1'b0;
      end else if (SOFT_RST) begin
         fail_code <= dbw_pkg::FAIL_NONE;
         uv_flag <= 1'b0;
      end else begin
         fail_code <= next_fail_code;
         uv_flag <= uv_active || (uv_flag && !clr_bus);
      end
   end

   // wake status register; sources latch in every mode, fail-safe included
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         buck_flag <= 1'b0;
         bus_wake <= 1'b0;
         timer_wake <= 1'b0;
         hv_wake <= 1'b0;
      end else if (SOFT_RST) begin
         buck_flag <= 1'b0;
         bus_wake <= 1'b0;
         timer_wake <= 1'b0;
         hv_wake <= 1'b0;
      end else begin
         buck_flag <= BUCK_MODE_AUTO_TRANSITION || (buck_flag && !clr_wake);
         bus_wake <= XCVR0_BUS_WAKE || (bus_wake && !clr_wake);
         timer_wake <= CYCLIC_TIMER_WAKE || (timer_wake && !clr_wake);
         hv_wake <= HV_INPUT_WAKE || (hv_wake && !clr_wake);
      end
   end

   // read port and fail output
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         REG_RDATA <= dbw_pkg::RST_BYTE;
         FAIL_OUTPUTS <= 1'b0;
      end else begin
         REG_RDATA <= REG_RD ? rd_mux : REG_RDATA;
         FAIL_OUTPUTS <= fo_flag;
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   sequence s_sleep_restart;
      RESTART && SLEEP_ACTIVE && !SOFT_RST;
   endsequence
   sequence s_fault_gone;
      tx_state == dbw_pkg::TX_RECOVER && !tx_fault && tx_done;
   endsequence

   prior_sleep_a: assert property (s_sleep_restart |=> prior == dbw_pkg::PRIOR_SLEEP)
      else $error("prior state not sleep after restart");
   wd_never_three_a: assert property (wd_count != dbw_pkg::WD_NEVER)
      else $error("watchdog count reached three");
   wd_trig_clear_a: assert property ((WD_TRIG_OK && !WATCHDOG_FAILURE_COUNT_EVT) |=>
      wd_count == dbw_pkg::WD_NONE)
      else $error("count kept after good trigger");
   wd_frozen_hold_a: assert property ((wd_frozen && !WD_TRIG_OK && !SOFT_RST) |=>
      wd_count == $past(wd_count))
      else $error("frozen count moved");
   spi_sticky_a: assert property ((spi_fail && !clr_dev && !SOFT_RST) |=> spi_fail)
      else $error("serial error lost without clear");
   fo_on_limit_a: assert property ((wd_hits && !SOFT_RST) |=> fo_flag ##1 FAIL_OUTPUTS)
      else $error("fail output not raised");
   rsv_zero_a: assert property ((rd_dev[5:4] == dbw_pkg::ZERO2) &&
      (rd_bus[7:3] == dbw_pkg::ZERO5) && !rd_wake[6] && (rd_wake[3:1] == dbw_pkg::ZERO3))
      else $error("reserved bit set");
   bus_code_a: assert property ((bus_exp && !SOFT_RST) |=> fail_code == dbw_pkg::FAIL_BUS)
      else $error("bus timeout not reported");
   uv_tx_off_a: assert property ((uv_active && !SOFT_RST) |=>
      !XCVR0_TX_ENABLE && uv_flag)
      else $error("undervoltage left transmitter on");
   uv_sticky_a: assert property ((uv_flag && !clr_bus && !SOFT_RST) |=> uv_flag)
      else $error("undervoltage flag lost without clear");
   txd_code_a: assert property ((txd_exp && !bus_exp && !SOFT_RST) |=>
      fail_code == dbw_pkg::FAIL_TXD)
      else $error("transmit timeout not reported");
   tsd_tx_off_a: assert property (tsd_s |=> !XCVR0_TX_ENABLE)
      else $error("transmitter left on in thermal shutdown");
   uv_gate_a: assert property ($rose(uv_flag) |-> $past(XCVR_MODE_HIGH_BIT))
      else $error("undervoltage flagged with comparator off");
   tx_reen_a: assert property (s_fault_gone |=> XCVR0_TX_ENABLE && $past(txd_s))
      else $error("transmitter not re-enabled");
   // a clear or soft reset right after the latch may drop it legally
   wake_latch_a: assert property ((HV_INPUT_WAKE && !SOFT_RST) |=> hv_wake ##1
      (hv_wake || $past(clr_wake) || $past(SOFT_RST)))
      else $error("wake input source not latched");
   soft_zero_a: assert property (SOFT_RST |=> rd_dev == dbw_pkg::RST_BYTE &&
      rd_bus == dbw_pkg::RST_BYTE && rd_wake == dbw_pkg::RST_BYTE)
      else $error("soft reset left status set");
endmodule : dbw_status_regs
`default_nettype wire

// ---- dv/dbw_host_model.sv ----
// host model: reads and clears the status registers, owns the transmit input
// assumes the bench clock is free running; drives change at the falling edge
`default_nettype none
module dbw_host_model (
   input wire logic core_clk,
   input wire logic [7:0] rdata,
   output logic [6:0] reg_addr,
   output logic reg_rd,
   output logic reg_clr,
   output logic txd
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_addr = 7'h00;
      reg_rd = 1'b0;
      reg_clr = 1'b0;
      txd = 1'b1;
   end

   // read is taken at the rising edge, data is settled at the next fall
   task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      // released address must not keep its old value
      reg_addr = ~a;
      d = rdata;
   endtask : read_reg

   // host clears what it has read so later events stand apart
   task automatic clear_reg(input logic [6:0] a);
      @(negedge core_clk);
      reg_addr = a;
      reg_clr = 1'b1;
      @(negedge core_clk);
      reg_clr = 1'b0;
      reg_addr = ~a;
   endtask : clear_reg

   // after dominant the input returns high and stays high
   task automatic hold_dominant(input int n);
      @(negedge core_clk);
      txd = 1'b0;
      repeat (n) @(negedge core_clk);
      txd = 1'b1;
   endtask : hold_dominant
endmodule : dbw_host_model
`default_nettype wire

// ---- dv/test_device_bus_wake_status_regs.sv ----
// testbench for the device, bus and wake status register bank
// assumes shortened dominant timeout (20) and enable time (4) in sim
`default_nettype none
module test_device_bus_wake_status_regs;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DOM = 20;
   logic core_clk, rst_n, sleep_active, stop_by_fail, cfg_pin, fo_first;
   logic bus_dom, supply_low, thermal_shutdown, mode_hi, wake_cap, tx_off, reg_rd, reg_clr, txd;
   // 0 soft, 1 restart, 2 watchdog_failure_count, 3 wd ok, 4 wd stop, 5 spi, 6 bus, 7 timer,
   // 8 hv, 9 buck
   logic soft_rst, restart, watchdog_failure_count, wd_ok, wd_stop;
   logic spi_bad, bus_wu, timer_wu, hv_wu, buck_wu;
   logic [6:0] reg_addr;
   logic [7:0] rdata;
   logic tx_en, fail_out;
   int n_errors, samples_checked, cycles;

   dbw_status_regs #(.DOM_LIMIT(DOM), .TXEN_LIMIT(4)) i_dut (
      .CORE_CLK(core_clk), .RST_N(rst_n), .SOFT_RST(soft_rst), .RESTART(restart),
      .SLEEP_ACTIVE(sleep_active), .WATCHDOG_FAILURE_COUNT_EVT(watchdog_failure_count), .WD_TRIG_OK(wd_ok),
      .WD_STOPPED(wd_stop), .WD_STOP_BY_FAIL(stop_by_fail),
      .INTERRUPT_CONFIG_PIN(cfg_pin), .CFG_FO_FIRST(fo_first), .SPI_INVALID(spi_bad),
      .XCVR0_TRANSMIT_INPUT(txd), .XCVR0_BUS_DOMINANT(bus_dom),
      .XCVR_SUPPLY_LOW(supply_low), .THERMAL_SHUTDOWN(thermal_shutdown), .XCVR_MODE_HIGH_BIT(mode_hi),
      .XCVR_WAKE_CAPABLE(wake_cap), .XCVR_TX_SWITCHED_OFF(tx_off),
      .XCVR0_BUS_WAKE(bus_wu), .CYCLIC_TIMER_WAKE(timer_wu), .HV_INPUT_WAKE(hv_wu),
      .BUCK_MODE_AUTO_TRANSITION(buck_wu), .REG_ADDR(reg_addr), .REG_RD(reg_rd),
      .REG_CLR(reg_clr), .REG_RDATA(rdata), .XCVR0_TX_ENABLE(tx_en), .FAIL_OUTPUTS(fail_out));

   dbw_host_model i_host (.core_clk(core_clk), .rdata(rdata), .reg_addr(reg_addr),
      .reg_rd(reg_rd), .reg_clr(reg_clr), .txd(txd));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_host.read_reg(a, d);
      chk(d, exp);
   endtask : rchk

   task automatic set_evt(input int i, input logic v);
      case (i)
         0: soft_rst = v;
         1: restart = v;
         2: watchdog_failure_count = v;
         3: wd_ok = v;
         4: wd_stop = v;
         5: spi_bad = v;
         6: bus_wu = v;
         7: timer_wu = v;
         8: hv_wu = v;
         default: buck_wu = v;
      endcase
   endtask : set_evt

   task automatic pulse(input int i);
      tick(1);
      set_evt(i, 1'b1);
      tick(1);
      set_evt(i, 1'b0);
   endtask : pulse

   task automatic tally_and_finish();
      $display("counts: %0d errors in %0d checks", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic t_device();
      pulse(5);
      rchk(7'h43, 8'h02);
      i_host.clear_reg(7'h43);
      rchk(7'h43, 8'h00);
      fo_first = 1'b1;
      pulse(2);
      rchk(7'h43, 8'h05);
      chk({7'h00, fail_out}, 8'h01);
      pulse(3);
      rchk(7'h43, 8'h01);
      i_host.clear_reg(7'h43);
      fo_first = 1'b0;
      pulse(2);
      rchk(7'h43, 8'h04);
      pulse(2);
      pulse(2);
      i_host.clear_reg(7'h43);
      rchk(7'h43, 8'h08);
      stop_by_fail = 1'b1;
      pulse(4);
      rchk(7'h43, 8'h08);
      stop_by_fail = 1'b0;
      pulse(4);
      rchk(7'h43, 8'h00);
      cfg_pin = 1'b0;
      // the config pin needs two edges through the synchroniser first
      tick(2);
      fo_first = 1'b1;
      pulse(2);
      pulse(4);
      rchk(7'h43, 8'h05);
      pulse(3);
      rchk(7'h43, 8'h01);
      i_host.clear_reg(7'h43);
      cfg_pin = 1'b1;
      sleep_active = 1'b1;
      pulse(1);
      rchk(7'h43, 8'h80);
      i_host.clear_reg(7'h43);
      sleep_active = 1'b0;
      pulse(5);
      pulse(1);
      rchk(7'h43, 8'h42);
   endtask : t_device

   task automatic t_wake();
      for (int i = 6; i < 10; i++) pulse(i);
      rchk(7'h46, 8'hb1);
      rchk(7'h45, 8'h00);
      pulse(1);
      rchk(7'h46, 8'hb1);
      i_host.clear_reg(7'h46);
      rchk(7'h46, 8'h00);
      pulse(7);
      pulse(0);
      rchk(7'h43, 8'h00);
      rchk(7'h46, 8'h00);
   endtask : t_wake

   task automatic t_bus();
      chk({7'h00, tx_en}, 8'h01);
      i_host.hold_dominant(15);
      tick(4);
      rchk(7'h44, 8'h00);
      i_host.hold_dominant(DOM + 10);
      chk({7'h00, tx_en}, 8'h00);
      tick(12);
      chk({7'h00, tx_en}, 8'h01);
      rchk(7'h44, 8'h04);
      i_host.clear_reg(7'h44);
      fork
         i_host.hold_dominant(DOM + 10);
         begin
            tick(15);
            tx_off = 1'b1;
            tick(1);
            tx_off = 1'b0;
         end
      join
      tick(4);
      rchk(7'h44, 8'h00);
      chk({7'h00, tx_en}, 8'h01);
      bus_dom = 1'b1;
      tick(15);
      wake_cap = 1'b1;
      tick(1);
      wake_cap = 1'b0;
      tick(15);
      tx_off = 1'b1;
      tick(1);
      tx_off = 1'b0;
      tick(15);
      bus_dom = 1'b0;
      tick(12);
      rchk(7'h44, 8'h00);
      bus_dom = 1'b1;
      tick(DOM + 10);
      rchk(7'h44, 8'h06);
      bus_dom = 1'b0;
      tick(12);
      chk({7'h00, tx_en}, 8'h01);
      i_host.clear_reg(7'h44);
      thermal_shutdown = 1'b1;
      tick(4);
      rchk(7'h44, 8'h02);
      chk({7'h00, tx_en}, 8'h00);
      thermal_shutdown = 1'b0;
      tick(12);
      chk({7'h00, tx_en}, 8'h01);
      pulse(1);
      rchk(7'h44, 8'h02);
      i_host.clear_reg(7'h44);
      supply_low = 1'b1;
      tick(5);
      rchk(7'h44, 8'h00);
      mode_hi = 1'b1;
      tick(4);
      rchk(7'h44, 8'h01);
      chk({7'h00, tx_en}, 8'h00);
      supply_low = 1'b0;
      tick(12);
      chk({7'h00, tx_en}, 8'h01);
      rchk(7'h44, 8'h01);
      i_host.clear_reg(7'h44);
      rchk(7'h44, 8'h00);
   endtask : t_bus

   initial begin
      rst_n = 1'b0;
      for (int i = 0; i < 10; i++) set_evt(i, 1'b0);
      sleep_active = 1'b0;
      stop_by_fail = 1'b0;
      fo_first = 1'b0;
      bus_dom = 1'b0;
      supply_low = 1'b0;
      thermal_shutdown = 1'b0;
      mode_hi = 1'b0;
      wake_cap = 1'b0;
      tx_off = 1'b0;
      cfg_pin = 1'b1;
      n_errors = 0;
      samples_checked = 0;
      cycles = 0;
      tick(2);
      rst_n = 1'b1;
      rchk(7'h43, 8'h00);
      rchk(7'h44, 8'h00);
      rchk(7'h46, 8'h00);
      t_device();
      t_wake();
      t_bus();
      tally_and_finish();
   end
endmodule : test_device_bus_wake_status_regs
`default_nettype wire
